// >>> hdl/fsq_params.svh
// Offsets, field positions, reset values and timing counts of the flash sequencer registers
`ifndef FSQ_PARAMS_SVH
`define FSQ_PARAMS_SVH

// ****************************************
// Register addresses
// ****************************************
`define FSQ_A_ACCESS_CTRL 20'hf_0090
`define FSQ_A_SEC_LO 20'hf_00b0
`define FSQ_A_SEC_HI 20'hf_00b1
`define FSQ_A_SHIELD_LO 20'hf_00b4
`define FSQ_A_SHIELD_HI 20'hf_00b5
`define FSQ_A_BANK_PAGE 16'hf_02c
`define FSQ_A_REG_CLEAR 20'hf_02c9
`define FSQ_A_STAT_LOW 20'hf_02ca
`define FSQ_A_STAT_HIGH 20'hf_02cb
`define FSQ_A_PROT_CMD 20'hf_02d0
`define FSQ_A_MODE_CTRL 20'hf_02d1
`define FSQ_A_PROT_STAT 20'hf_02d2

// ****************************************
// Sequencer bank indices (low nibble of address)
// ****************************************
`define FSQ_B_START_LO 4'h0
`define FSQ_B_START_HI 4'h1
`define FSQ_B_END_LO 4'h2
`define FSQ_B_END_HI 4'h3
`define FSQ_B_WDATA_LO 4'h4
`define FSQ_B_WDATA_HI 4'h5
`define FSQ_B_AREA_SEL 4'h6
`define FSQ_B_MAIN_CMD 4'h7
`define FSQ_B_EXTRA_CMD 4'h8
`define FSQ_BANK_LAST 4'h8

// ****************************************
// Field positions, masks, codes, reset values
// ****************************************
`define FSQ_BIT_START 7
`define FSQ_BIT_AREA_EXTRA 0
`define FSQ_BIT_CLEAR 0
`define FSQ_BIT_ACCESS_EN 0
`define FSQ_SEC_BOOT_SWAP 8
`define FSQ_SEC_MASK 16'h170b
`define FSQ_SHIELD_MASK 16'h81ff
`define FSQ_PROT_KEY 8'ha5
`define FSQ_MODE_CODE 8'h02
`define FSQ_MODE_DATA 8'h10
`define FSQ_MCMD_WRITE 4'h1
`define FSQ_MCMD_BLANK_CODE 4'h3
`define FSQ_MCMD_BLANK_DATA 4'hb
`define FSQ_MCMD_ERASE 4'h4
`define FSQ_XCMD_SHIELD 4'h1
`define FSQ_XCMD_READ_PROT 4'h6
`define FSQ_XCMD_SECURITY 4'h7
`define FSQ_RST_BYTE 8'h00

// ****************************************
// Timing
// ****************************************
`define FSQ_CLK_MHZ 20
`define FSQ_OP_TIME_NS 1000
`define FSQ_OP_CYCLES ((`FSQ_OP_TIME_NS * `FSQ_CLK_MHZ + 999) / 1000)
`define FSQ_CNT_W 8

`endif

// >>> hdl/fsq_pkg.sv
// Types shared by the flash sequencer register block
package fsq_pkg;
	// Flash control modes
	typedef enum logic [1:0] {FSQ_M_OFF, FSQ_M_CODE, FSQ_M_DATA} fsq_mode_t;
	// Steps of the mode-change unlock sequence
	typedef enum logic [1:0] {SS_IDLE, SS_KEYED, SS_VALUE, SS_INVERSE} fsq_spec_t;
endpackage

// >>> hdl/fsq_regs.sv
// Flash sequencer control, status, protection and monitor registers
`timescale 1ns/1ns
`include "fsq_params.svh"

// Notes on behaviour
// - Clear bit resets address, data, area, commands
// - Clearing acts only with both end flags zero
// - High status: extra end bit7, main end bit6
// - Low status holds boot, open and error flags
// - Security monitor: write, erase, boot rewrite permits
// - Boot swap bit picks boot cluster
// - Bit 3 shows read-protect change permitted
// - Bit 1 debug connect; bit 0 ID auth off
// - Shield bit 15 selects inside or outside window
// - Shield bits 8..0 hold end block plus one
// - Access control bit 0 gates data/extra areas
// - Access control accepts bit and byte writes
// - Three modes gate which areas may be rewritten
// - Key, value, inverse, value changes the mode
// - Stray write in sequence suppressed, error flagged
module fsq_regs
	import fsq_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic reset_i,
	// Register port
	input wire logic [19:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	// Extra area contents and flash array result
	input wire logic [15:0] sec_nv_i,
	input wire logic [15:0] shield_nv_i,
	input wire logic op_fail_i,
	// Mode and status towards the flash array
	output logic code_rewrite_o,
	output logic data_rewrite_o,
	output logic area_access_o,
	output logic boot_cluster0_o,
	output logic [1:0] seq_busy_o
);

	// ****************************************
	// Storage
	// ****************************************
	logic [7:0] bank_q [0:8]; // Address, data, area and command bytes
	logic access_en_q; // Data/extra area access enable
	logic clear_q; // Register-clear bit
	logic [7:0] pmc_q; // Active mode control value
	logic [7:0] first_q; // Value seen at the first mode step
	fsq_spec_t spec_q; // Unlock sequence step
	logic prot_err_q; // Protection error flag
	logic [15:0] sec_q; // Security flag monitor
	logic [15:0] shield_q; // Shield window end monitor
	logic load_q; // Monitor load pending after reset
	logic blank_err_q, write_err_q, erase_err_q; // Main operation results
	logic [7:0] rdata_q; // Registered read data
	logic [7:0] rd_mux; // Read selection
	logic [1:0] busy_w, end_w, err_w, fin_w; // Per-sequencer state views
	logic [1:0] legal_w, permit_w; // Command legality and mode permission
	fsq_mode_t mode; // Decoded control mode

	// ****************************************
	// Address decode
	// ****************************************
	wire in_bank = (addr_i[19:4] == `FSQ_A_BANK_PAGE) && (addr_i[3:0] <= `FSQ_BANK_LAST);
	wire [3:0] bank_idx = addr_i[3:0];
	wire hit_access = addr_i == `FSQ_A_ACCESS_CTRL;
	wire hit_clear = addr_i == `FSQ_A_REG_CLEAR;
	wire hit_prot = addr_i == `FSQ_A_PROT_CMD;
	wire hit_pmc = addr_i == `FSQ_A_MODE_CTRL;
	// Interlocks and unlock sequence decode
	wire stopped = ~|end_w & ~|busy_w;
	wire clr_act = clear_q & stopped;
	wire seq_open = spec_q != SS_IDLE;
	// Key only taken with clear bit low and sequencers idle
	wire key_wr = wr_i & hit_prot & (wdata_i == `FSQ_PROT_KEY) & ~clear_q & stopped;
	wire pmc_wr = wr_i & hit_pmc & seq_open;
	wire stray_wr = wr_i & seq_open & ~hit_pmc & ~key_wr;
	wire pmc_bad = pmc_wr & ((spec_q == SS_VALUE) ? (wdata_i != ~first_q) :
		(spec_q == SS_INVERSE) ? (wdata_i != first_q) : 1'b0);
	wire prot_fault = stray_wr | pmc_bad;
	// Ordinary writes are suppressed while the sequence is open
	wire wr_ok = wr_i & ~seq_open;

	// ****************************************
	// Mode decode
	// ****************************************
	// Only the exact code or data values open a programming mode
	assign mode = (pmc_q == `FSQ_MODE_CODE) ? FSQ_M_CODE :
		(pmc_q == `FSQ_MODE_DATA) ? FSQ_M_DATA : FSQ_M_OFF;
	wire area_extra = bank_q[`FSQ_B_AREA_SEL][`FSQ_BIT_AREA_EXTRA];
	wire [3:0] cmd_new = wdata_i[3:0];

	// Main commands need a programming mode; data mode also needs access
	assign legal_w[0] = (cmd_new == `FSQ_MCMD_WRITE) | (cmd_new == `FSQ_MCMD_BLANK_CODE) |
		(cmd_new == `FSQ_MCMD_BLANK_DATA) | (cmd_new == `FSQ_MCMD_ERASE);
	assign permit_w[0] = ((mode == FSQ_M_CODE) | ((mode == FSQ_M_DATA) & access_en_q))
		& ~area_extra;
	// Extra commands need code mode, extra area selected and access on
	assign legal_w[1] = (cmd_new == `FSQ_XCMD_SHIELD) | (cmd_new == `FSQ_XCMD_READ_PROT) |
		(cmd_new == `FSQ_XCMD_SECURITY);
	assign permit_w[1] = (mode == FSQ_M_CODE) & access_en_q & area_extra;

	// ****************************************
	// Sequencers: main (0) and extra area (1)
	// ****************************************
	localparam logic [`FSQ_CNT_W-1:0] OP_LOAD = `FSQ_CNT_W'(`FSQ_OP_CYCLES - 1);
	genvar c;
	generate
		for (c = 0; c < 2; c++) begin : g_seq
			localparam logic [3:0] IDX = (c == 0) ? `FSQ_B_MAIN_CMD : `FSQ_B_EXTRA_CMD;
			logic busy_q, end_q, err_q; // Running, finished, command refused
			logic [`FSQ_CNT_W-1:0] cnt_q; // Cycles left in the operation
			wire cmd_hit = wr_ok & in_bank & (bank_idx == IDX) & ~clr_act;
			wire go_req = cmd_hit & wdata_i[`FSQ_BIT_START] & ~busy_q & ~end_q;
			wire go_ok = go_req & legal_w[c] & permit_w[c];
			wire go_bad = go_req & ~(legal_w[c] & permit_w[c]);
			wire stop_req = cmd_hit & ~wdata_i[`FSQ_BIT_START];
			wire fin = busy_q & (cnt_q == '0);

			// Run, finish and stop; a finishing edge beats a stop write
			always_ff @(posedge clk_i) begin
				if (reset_i) begin
					busy_q <= 1'b0;
					end_q <= 1'b0;
					err_q <= 1'b0;
					cnt_q <= '0;
				end else begin
					if (go_ok) begin
						busy_q <= 1'b1;
						cnt_q <= OP_LOAD;
						err_q <= 1'b0;
					end else if (fin) begin
						busy_q <= 1'b0;
					end else if (busy_q) begin
						cnt_q <= cnt_q - 1'b1;
					end
					// Refused command ends at once with the error bit set
					if (go_bad) begin
						err_q <= 1'b1;
					end
					if (fin | go_bad) begin
						end_q <= 1'b1;
					end else if (stop_req) begin
						end_q <= 1'b0;
					end
				end
			end
			assign busy_w[c] = busy_q;
			assign end_w[c] = end_q;
			assign err_w[c] = err_q;
			assign fin_w[c] = fin;
		end
	endgenerate

	// Main operation result flags
	wire [3:0] main_cmd = bank_q[`FSQ_B_MAIN_CMD][3:0];
	wire is_blank = (main_cmd == `FSQ_MCMD_BLANK_CODE) | (main_cmd == `FSQ_MCMD_BLANK_DATA);
	wire main_go = wr_ok & in_bank & (bank_idx == `FSQ_B_MAIN_CMD) & wdata_i[`FSQ_BIT_START];

	// Cleared at a new start, set from the array result at finish
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			blank_err_q <= 1'b0;
			write_err_q <= 1'b0;
			erase_err_q <= 1'b0;
		end else if (fin_w[0]) begin
			blank_err_q <= op_fail_i & is_blank;
			write_err_q <= op_fail_i & (main_cmd == `FSQ_MCMD_WRITE);
			erase_err_q <= op_fail_i & (main_cmd == `FSQ_MCMD_ERASE);
		end else if (main_go & ~busy_w[0] & ~end_w[0]) begin
			blank_err_q <= 1'b0;
			write_err_q <= 1'b0;
			erase_err_q <= 1'b0;
		end
	end

	// ****************************************
	// Sequencer bank with register clear
	// ****************************************
	// Held at initial values while the clear bit is set and both are stopped
	always_ff @(posedge clk_i) begin
		if (reset_i || clr_act) begin
			for (int i = 0; i < 9; i++) begin
				bank_q[i] <= `FSQ_RST_BYTE;
			end
		end else if (wr_ok && in_bank) begin
			bank_q[bank_idx] <= wdata_i;
		end
	end

	// ****************************************
	// Clear bit and access control
	// ****************************************
	// Only bit 0 of each is stored; byte or bit writes land alike
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			clear_q <= 1'b0;
			access_en_q <= 1'b0;
		end else if (wr_ok) begin
			if (hit_clear) begin
				clear_q <= wdata_i[`FSQ_BIT_CLEAR];
			end
			if (hit_access) begin
				access_en_q <= wdata_i[`FSQ_BIT_ACCESS_EN];
			end
		end
	end

	// ****************************************
	// Mode unlock sequence
	// ****************************************
	// Key restarts and clears the error; any misstep aborts with error
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			spec_q <= SS_IDLE;
			prot_err_q <= 1'b0;
			pmc_q <= `FSQ_RST_BYTE;
			first_q <= `FSQ_RST_BYTE;
		end else if (key_wr) begin
			spec_q <= SS_KEYED;
			prot_err_q <= 1'b0;
		end else if (prot_fault) begin
			spec_q <= SS_IDLE;
			prot_err_q <= 1'b1;
		end else if (pmc_wr) begin
			unique case (spec_q)
				SS_KEYED: begin
					first_q <= wdata_i;
					spec_q <= SS_VALUE;
				end
				SS_VALUE: begin
					spec_q <= SS_INVERSE;
				end
				SS_INVERSE: begin
					pmc_q <= wdata_i;
					spec_q <= SS_IDLE;
				end
				SS_IDLE: begin
					spec_q <= SS_IDLE;
				end
			endcase
		end
	end

	// ****************************************
	// Monitors loaded from the extra area
	// ****************************************
	// Captured on the first edge after reset is released
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			load_q <= 1'b1;
			sec_q <= 16'h0000;
			shield_q <= 16'h0000;
		end else if (load_q) begin
			load_q <= 1'b0;
			sec_q <= sec_nv_i & `FSQ_SEC_MASK;
			shield_q <= shield_nv_i & `FSQ_SHIELD_MASK;
		end
	end

	// ****************************************
	// Read selection and output
	// ****************************************
	wire boot_swap = sec_q[`FSQ_SEC_BOOT_SWAP];
	wire open_mon = mode != FSQ_M_OFF;

	// Unmapped addresses read zero
	always_comb begin
		rd_mux = 8'h00;
		if (in_bank) begin
			rd_mux = bank_q[bank_idx];
		end else begin
			case (addr_i)
				`FSQ_A_ACCESS_CTRL: rd_mux = {7'h00, access_en_q};
				`FSQ_A_SEC_LO: rd_mux = sec_q[7:0];
				`FSQ_A_SEC_HI: rd_mux = sec_q[15:8];
				`FSQ_A_SHIELD_LO: rd_mux = shield_q[7:0];
				`FSQ_A_SHIELD_HI: rd_mux = shield_q[15:8];
				`FSQ_A_REG_CLEAR: rd_mux = {7'h00, clear_q};
				`FSQ_A_STAT_LOW: rd_mux = {boot_swap, open_mon, err_w[1], err_w[0],
					blank_err_q, 1'b0, write_err_q, erase_err_q};
				`FSQ_A_STAT_HIGH: rd_mux = {end_w[1], end_w[0], 6'h00};
				`FSQ_A_MODE_CTRL: rd_mux = pmc_q;
				`FSQ_A_PROT_STAT: rd_mux = {7'h00, prot_err_q};
				default: rd_mux = 8'h00;
			endcase
		end
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			rdata_q <= 8'h00;
		end else begin
			rdata_q <= rd_i ? rd_mux : 8'h00;
		end
	end

	assign rdata_o = rdata_q;
	assign code_rewrite_o = mode == FSQ_M_CODE;
	assign data_rewrite_o = mode == FSQ_M_DATA;
	assign area_access_o = access_en_q;
	// Swap flag 1 selects cluster 0, flag 0 selects cluster 1
	assign boot_cluster0_o = boot_swap;
	assign seq_busy_o = busy_w;

	// ****************************************
	// Assertions
	// ****************************************
	localparam int OP_DONE = `FSQ_OP_CYCLES + 1;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);

	sequence s_keyed;
		key_wr ##1 (spec_q == SS_KEYED);
	endsequence
	sequence s_last_step;
		(spec_q == SS_INVERSE) && pmc_wr && !pmc_bad;
	endsequence

	AST_CLEAR_RESETS_BANK: assert property (clr_act |=> bank_q[`FSQ_B_MAIN_CMD] == 8'h00 &&
		bank_q[`FSQ_B_START_LO] == 8'h00) else $error("bank not cleared by clear bit");
	AST_CLEAR_HOLDS_BANK: assert property (clear_q && !stopped && !(wr_ok && in_bank)
		|=> $stable(bank_q[`FSQ_B_WDATA_LO])) else $error("bank cleared while a sequencer ran");
	AST_CLEAR_NEEDS_STOP: assert property (clear_q && !stopped && wr_ok && in_bank
		|=> bank_q[$past(bank_idx)] == $past(wdata_i))
		else $error("clear acted while a sequencer ran");
	AST_HIGH_STATUS: assert property (rd_i && addr_i == `FSQ_A_STAT_HIGH
		|=> rdata_o == {$past(end_w[1]), $past(end_w[0]), 6'h00})
		else $error("high status read wrong");
	AST_LOW_STATUS: assert property (rd_i && addr_i == `FSQ_A_STAT_LOW
		|=> !rdata_o[2] && rdata_o[7] == $past(sec_q[`FSQ_SEC_BOOT_SWAP]))
		else $error("low status read wrong");
	AST_SEC_HIGH: assert property (rd_i && addr_i == `FSQ_A_SEC_HI
		|=> rdata_o == ($past(sec_q[15:8]) & 8'h17))
		else $error("security monitor high byte wrong");
	AST_BOOT_SWAP: assert property (load_q |=> boot_cluster0_o == $past(sec_nv_i[8]))
		else $error("boot cluster select disagrees with swap flag");
	AST_SEC_LOW: assert property (rd_i && addr_i == `FSQ_A_SEC_LO
		|=> rdata_o[7:4] == 4'h0 && rdata_o[2] == 1'b0 && rdata_o[3] == $past(sec_q[3]))
		else $error("security monitor low byte wrong");
	AST_SHIELD_HIGH: assert property (rd_i && addr_i == `FSQ_A_SHIELD_HI
		|=> rdata_o[6:1] == 6'h00 && rdata_o[7] == $past(shield_q[15]))
		else $error("shield monitor high byte wrong");
	AST_ACCESS_WRITE: assert property (wr_ok && hit_access
		|=> area_access_o == $past(wdata_i[0]))
		else $error("access enable not taken");
	AST_OP_FINISH: assert property (g_seq[0].go_ok |-> ##[OP_DONE:OP_DONE] end_w[0])
		else $error("main operation did not end on time");
	AST_MODE_OFF_REFUSE: assert property (mode == FSQ_M_OFF && g_seq[0].go_req
		|=> err_w[0] && end_w[0] && !busy_w[0])
		else $error("command ran in rewrite-disabled mode");
	AST_KEY_OPENS: assert property (s_keyed |-> !prot_err_q)
		else $error("key did not restart the sequence");
	AST_MODE_COMMIT: assert property (s_last_step |=> pmc_q == $past(wdata_i))
		else $error("mode value not committed");
	AST_STRAY_WRITE: assert property (stray_wr && !key_wr
		|=> prot_err_q && spec_q == SS_IDLE && $stable(access_en_q))
		else $error("stray write not flagged");
	AST_MONITOR_LOAD: assert property (load_q |=>
		sec_q == ($past(sec_nv_i) & 16'h170b) && !load_q)
		else $error("security monitor not loaded");
endmodule

// >>> testbench/test_flash_seq_status_and_protect_regs.sv
// Self-checking bench for the flash sequencer register block
`timescale 1ns/1ns
`include "fsq_params.svh"
module test_flash_seq_status_and_protect_regs;
	// ****************************************
	// Signals
	// ****************************************
	logic clk_i; // Bench clock
	logic reset_i; // Synchronous reset
	logic [19:0] addr_i; // Register address
	logic [7:0] wdata_i; // Write data
	logic wr_i; // Write strobe
	logic rd_i; // Read strobe
	logic [7:0] rdata_o; // Read data
	logic [15:0] sec_nv_i; // Stored security word
	logic [15:0] shield_nv_i; // Stored shield word
	logic op_fail_i; // Array result
	logic code_rewrite_o; // Code mode active
	logic data_rewrite_o; // Data mode active
	logic area_access_o; // Area access enable
	logic boot_cluster0_o; // Boot cluster select
	logic [1:0] seq_busy_o; // Sequencers running
	int fails; // Mismatch count
	int checked; // Comparison count
	int cycles; // Timeout counter
	int n; // Cycle count of an operation
	logic [7:0] codes [4]; // Main command codes
	logic [7:0] errs [4]; // Expected result flag per code
	logic [7:0] xcodes [3]; // Extra command codes

	// ****************************************
	// Design under test
	// ****************************************
	fsq_regs DUT (
		.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .sec_nv_i(sec_nv_i),
		.shield_nv_i(shield_nv_i), .op_fail_i(op_fail_i),
		.code_rewrite_o(code_rewrite_o), .data_rewrite_o(data_rewrite_o),
		.area_access_o(area_access_o), .boot_cluster0_o(boot_cluster0_o),
		.seq_busy_o(seq_busy_o)
	);

	// ****************************************
	// Clock and timeout
	// ****************************************
	// 20 MHz clock
	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end

	// Cut a hang short well past the expected run length
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			fails = fails + 1;
			final_report();
		end
	end

	// ****************************************
	// Tasks
	// ****************************************
	// Compare seen against expected
	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		checked = checked + 1;
		if (got !== exp) begin
			fails = fails + 1;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask

	// One write cycle, then one idle cycle
	task automatic wr(input logic [19:0] a, input logic [7:0] d);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge clk_i);
		wr_i <= 1'b0;
		@(posedge clk_i);
	endtask

	// One read cycle; data sampled in the cycle after the strobe
	task automatic rdchk(input string name, input logic [19:0] a, input logic [7:0] m,
		input logic [7:0] exp);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge clk_i);
		rd_i <= 1'b0;
		@(posedge clk_i);
		chk(name, {8'h00, exp}, {8'h00, rdata_o & m});
	endtask

	// Key, value, inverse, value
	task automatic mode(input logic [7:0] v);
		wr(20'hf_02d0, 8'ha5);
		wr(20'hf_02d1, v);
		wr(20'hf_02d1, ~v);
		wr(20'hf_02d1, v);
	endtask

	// Start a sequencer and count cycles until busy falls
	task automatic run_op(input logic [19:0] a, input logic [7:0] c, input int idx);
		wr(a, c);
		n = 1;
		while (seq_busy_o[idx] === 1'b1 && n < 100) begin
			@(posedge clk_i);
			n = n + 1;
		end
		chk("op_cycles", 16'(`FSQ_OP_CYCLES + 1), 16'(n));
	endtask

	// Verdict and end of run
	task automatic final_report();
		if (fails == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		fails = 0;
		checked = 0;
		cycles = 0;
		reset_i = 1'b1;
		addr_i = 20'h0_0000;
		wdata_i = 8'h00;
		wr_i = 1'b0;
		rd_i = 1'b0;
		op_fail_i = 1'b0;
		sec_nv_i = 16'hffff;
		shield_nv_i = 16'hfe05;
		codes = '{8'h81, 8'h83, 8'h8b, 8'h84};
		errs = '{8'h02, 8'h08, 8'h08, 8'h01};
		xcodes = '{8'h81, 8'h86, 8'h87};
		repeat (3) @(posedge clk_i);
		reset_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		// Reset values and monitors
		rdchk("access_rst", 20'hf_0090, 8'hff, 8'h00);
		rdchk("clear_rst", 20'hf_02c9, 8'hff, 8'h00);
		rdchk("stat_high_rst", 20'hf_02cb, 8'hff, 8'h00);
		rdchk("sec_lo", 20'hf_00b0, 8'hff, 8'h0b);
		rdchk("sec_hi", 20'hf_00b1, 8'hff, 8'h17);
		rdchk("shield_lo", 20'hf_00b4, 8'hff, 8'h05);
		rdchk("shield_hi", 20'hf_00b5, 8'hff, 8'h80);
		chk("boot_cluster0", 16'h0001, {15'h0000, boot_cluster0_o});
		// Access control, reserved bits dropped
		wr(20'hf_0090, 8'hff);
		rdchk("access_rd", 20'hf_0090, 8'hff, 8'h01);
		chk("area_access", 16'h0001, {15'h0000, area_access_o});
		// All three modes
		mode(8'h02);
		chk("code_mode", 16'h0002, {14'h0000, code_rewrite_o, data_rewrite_o});
		rdchk("open_mon", 20'hf_02ca, 8'h40, 8'h40);
		mode(8'h10);
		chk("data_mode", 16'h0001, {14'h0000, code_rewrite_o, data_rewrite_o});
		mode(8'h00);
		chk("off_mode", 16'h0000, {14'h0000, code_rewrite_o, data_rewrite_o});
		// Stray write inside the sequence
		wr(20'hf_02d0, 8'ha5);
		wr(20'hf_02d1, 8'h02);
		wr(20'hf_0090, 8'h00);
		rdchk("stray_drop", 20'hf_0090, 8'hff, 8'h01);
		rdchk("prot_err", 20'hf_02d2, 8'h01, 8'h01);
		wr(20'hf_02d1, 8'hfd);
		wr(20'hf_02d1, 8'h02);
		chk("aborted_mode", 16'h0000, {14'h0000, code_rewrite_o, data_rewrite_o});
		wr(20'hf_02d0, 8'ha5);
		rdchk("prot_err_clr", 20'hf_02d2, 8'h01, 8'h00);
		wr(20'hf_02d1, 8'h02);
		wr(20'hf_02d1, 8'hfd);
		wr(20'hf_02d1, 8'h02);
		chk("code_again", 16'h0002, {14'h0000, code_rewrite_o, data_rewrite_o});
		// Register clear while stopped
		wr(20'hf_02c0, 8'h12);
		wr(20'hf_02c4, 8'h5a);
		wr(20'hf_02c9, 8'h01);
		rdchk("clr_start", 20'hf_02c0, 8'hff, 8'h00);
		rdchk("clr_wdata", 20'hf_02c4, 8'hff, 8'h00);
		rdchk("clr_bit", 20'hf_02c9, 8'hff, 8'h01);
		wr(20'hf_02c9, 8'h00);
		wr(20'hf_02c4, 8'h5a);
		wr(20'hf_02c6, 8'h00);
		op_fail_i <= 1'b1;
		// Every main command, failing
		for (int i = 0; i < 4; i++) begin
			run_op(20'hf_02c7, codes[i], 0);
			rdchk("main_end", 20'hf_02cb, 8'hff, 8'h40);
			rdchk("main_err", 20'hf_02ca, 8'h3f, errs[i]);
			if (i == 0) begin
				wr(20'hf_02c9, 8'h01);
				rdchk("clr_blocked", 20'hf_02c4, 8'hff, 8'h5a);
				wr(20'hf_02c9, 8'h00);
			end
			wr(20'hf_02c7, codes[i] & 8'h7f);
			rdchk("main_stop", 20'hf_02cb, 8'hff, 8'h00);
		end
		op_fail_i <= 1'b0;
		// Every extra command
		wr(20'hf_02c6, 8'h01);
		for (int i = 0; i < 3; i++) begin
			run_op(20'hf_02c8, xcodes[i], 1);
			rdchk("extra_end", 20'hf_02cb, 8'hff, 8'h80);
			wr(20'hf_02c8, xcodes[i] & 8'h7f);
			rdchk("extra_stop", 20'hf_02cb, 8'hff, 8'h00);
		end
		// Illegal extra command
		wr(20'hf_02c8, 8'h82);
		chk("refused_busy", 16'h0000, {14'h0000, seq_busy_o});
		rdchk("refused_end", 20'hf_02cb, 8'hff, 8'h80);
		rdchk("refused_err", 20'hf_02ca, 8'h20, 8'h20);
		wr(20'hf_02c8, 8'h02);
		// Main command refused in rewrite-disabled mode
		mode(8'h00);
		wr(20'hf_02c6, 8'h00);
		wr(20'hf_02c7, 8'h81);
		chk("off_busy", 16'h0000, {14'h0000, seq_busy_o});
		rdchk("off_end", 20'hf_02cb, 8'hff, 8'h40);
		rdchk("off_err", 20'hf_02ca, 8'h10, 8'h10);
		wr(20'hf_02c7, 8'h01);
		final_report();
	end
endmodule
